// ### adc_seq_consts.svh
`ifndef ADC_SEQ_CONSTS_SVH
`define ADC_SEQ_CONSTS_SVH

// register byte offsets on the bus
`define OFF_CTRL0    12'h000
`define OFF_CTRL1    12'h004
`define OFF_CTRL2    12'h008
`define OFF_RES_HIGH 12'h00c
`define OFF_RES_LOW  12'h010
`define OFF_IRQ      12'h014

// field positions
`define C0_ENABLE 0
`define C0_GO     1
`define C0_CHAN   6:2
`define C1_FMT    7
`define C1_CLK    6:4
`define C1_REF    1:0
`define C2_TRIG   7:3
`define IRQ_FLAG  0
`define IRQ_EN    1

// reset values
`define CTRL_RESET 8'h00
`define RES_RESET  8'h00

// encodings
`define CLK_RC     2'b11
`define CH_EXT_MAX 5'h0b
`define CH_TEMP    5'h1d
`define CH_DAC     5'h1e
`define CH_FIXED   5'h1f
`define TRIG_NONE  5'h00

// conversion timing in half periods of the bit clock, and the index of the top result bit
`define SAMPLE_HALVES 5'd3
`define CONV_HALVES   5'd23
`define MSB_IDX       4'd9

`endif

// ### adc_seq_pkg.sv
package adc_seq_pkg;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_SAMPLE  = 2'b01,
    ST_CONVERT = 2'b10
  } conv_state_e;

  typedef enum logic [1:0] {
    REF_SUPPLY   = 2'b00,
    REF_RESERVED = 2'b01,
    REF_PIN      = 2'b10,
    REF_FIXED    = 2'b11
  } ref_sel_e;

  typedef struct packed {
    logic        power;
    logic        sample;
    logic [9:0]  trial;
    logic        ext_en;
    logic [3:0]  ext_chan;
    logic        temp_en;
    logic        dac_en;
    logic        fixed_en;
    ref_sel_e    ref_src;
    logic        ref_valid;
  } core_ctrl_s;

endpackage : adc_seq_pkg

// ### adc_conversion_sequencer.sv
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "adc_seq_consts.svh"

module adc_conversion_sequencer #(
  parameter int NUM_TRIG = 32
) (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     ce,
  // apb slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [11:0]              paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  // analog core
  input  wire logic                     cmp_in,
  input  wire logic                     rc_tick,
  output adc_seq_pkg::core_ctrl_s       core_ctrl,
  // trigger sources
  input  wire logic [NUM_TRIG-1:0]      trig_src,
  // system
  input  wire logic                     sleep,
  output logic                          wake,
  output logic                          irq
);

  logic                     conv_enable;
  logic [4:0]               channel_select;
  logic                     result_format_sel;
  logic [2:0]               conv_clock_select;
  logic [1:0]               pos_ref_select;
  logic [4:0]               trigger_select;
  logic [7:0]               result_high;
  logic [7:0]               result_low;
  logic                     conv_done_flag;
  logic                     conv_irq_enable;
  adc_seq_pkg::conv_state_e state;
  logic [4:0]               half_cnt;
  logic [5:0]               div_cnt;
  logic [9:0]               code;
  logic [3:0]               bit_idx;
  logic                     sub;
  logic                     trig_prev;
  logic                     sleep_off;

  // bus decode
  logic apb_wr, wr0, wr1, wr2, wr_irq;
  assign apb_wr = psel && penable && pready && pwrite && ce;
  assign wr0    = apb_wr && (paddr == `OFF_CTRL0);
  assign wr1    = apb_wr && (paddr == `OFF_CTRL1);
  assign wr2    = apb_wr && (paddr == `OFF_CTRL2);
  assign wr_irq = apb_wr && (paddr == `OFF_IRQ);

  // conversion events
  logic busy, is_rc, trig_edge, sw_start, hw_start, start;
  logic sw_abort, sleep_abort, en_off, half_tick, done_ev;
  logic [5:0] half_lim;
  logic [9:0] final_code;

  assign busy      = (state != adc_seq_pkg::ST_IDLE);
  assign is_rc     = (conv_clock_select[1:0] == `CLK_RC);
  // divide 2,4,8,16,32,64 map to shifts 0..5 through a bit rotation
  assign half_lim  = 6'((6'd1 << {conv_clock_select[1:0], conv_clock_select[2]}) - 6'd1);
  assign half_tick = is_rc ? rc_tick : (div_cnt == half_lim);
  assign trig_edge = trig_src[trigger_select] && !trig_prev
                     && (trigger_select != `TRIG_NONE);
  // go only taken once the converter is already on, never in the same write
  assign sw_start  = wr0 && pwdata[`C0_GO] && conv_enable && !busy;
  assign hw_start  = ce && trig_edge && conv_enable && !busy;
  assign start     = (sw_start || hw_start) && !sleep_off && !(sleep && !is_rc);
  assign sw_abort  = wr0 && !pwdata[`C0_GO] && busy;
  assign en_off    = wr0 && !pwdata[`C0_ENABLE] && busy;
  assign sleep_abort = ce && sleep && !is_rc && busy;
  assign done_ev   = ce && (state == adc_seq_pkg::ST_CONVERT) && half_tick && sub
                     && (bit_idx == 4'd0) && !sw_abort && !en_off && !sleep_abort;
  assign final_code = {code[9:1], cmp_in};

  // the current trial bit and the bits below it copy the last resolved bit
  function automatic logic [9:0] partial_code(input logic [9:0] c, input logic [3:0] idx,
                                              input logic converting);
    logic [9:0] r;
    logic       fill;
    r    = c;
    fill = 1'b0;
    if (converting && idx != `MSB_IDX)
      fill = c[idx + 4'd1];
    for (int i = 0; i < 10; i++) begin
      if (i <= int'(idx))
        r[i] = fill;
    end
    return r;
  endfunction : partial_code

  function automatic logic [15:0] format_result(input logic [9:0] r, input logic fm);
    return fm ? {6'h00, r} : {r, 6'h00};
  endfunction : format_result

  // control registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_enable       <= 1'b0;
      channel_select    <= 5'h00;
      result_format_sel <= 1'b0;
      conv_clock_select <= 3'h0;
      pos_ref_select    <= 2'h0;
      trigger_select    <= 5'h00;
      conv_irq_enable   <= 1'b0;
    end else if (ce) begin
      if (wr0) begin
        conv_enable    <= pwdata[`C0_ENABLE];
        channel_select <= pwdata[`C0_CHAN];
      end
      if (wr1) begin
        result_format_sel <= pwdata[`C1_FMT];
        conv_clock_select <= pwdata[`C1_CLK];
        pos_ref_select    <= pwdata[`C1_REF];
      end
      if (wr2)
        trigger_select <= pwdata[`C2_TRIG];
      if (wr_irq)
        conv_irq_enable <= pwdata[`IRQ_EN];
    end
  end

  // done flag: a completion in the clearing cycle wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      conv_done_flag <= 1'b0;
    else if (ce)
      conv_done_flag <= done_ev || (conv_done_flag && !(wr_irq && !pwdata[`IRQ_FLAG]));
  end

  // result bytes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_high <= `RES_RESET;
      result_low  <= `RES_RESET;
    end else if (ce) begin
      if (done_ev)
        {result_high, result_low} <= format_result(final_code, result_format_sel);
      else if (sw_abort && !en_off)
        {result_high, result_low} <= format_result(
          partial_code(code, bit_idx, state == adc_seq_pkg::ST_CONVERT), result_format_sel);
    end
  end

  // trigger edge history
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      trig_prev <= 1'b0;
    else if (ce)
      trig_prev <= trig_src[trigger_select];
  end

  // bit clock divider, restarted with each conversion
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      div_cnt <= 6'd0;
    else if (ce) begin
      if (start || !busy || half_tick)
        div_cnt <= 6'd0;
      else
        div_cnt <= div_cnt + 6'd1;
    end
  end

  // successive approximation sequence
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= adc_seq_pkg::ST_IDLE;
      half_cnt <= 5'd0;
      code     <= 10'h000;
      bit_idx  <= `MSB_IDX;
      sub      <= 1'b0;
    end else if (ce) begin
      if (start) begin
        state    <= adc_seq_pkg::ST_SAMPLE;
        half_cnt <= 5'd0;
        code     <= 10'h000;
        bit_idx  <= `MSB_IDX;
        sub      <= 1'b0;
      end else if (sw_abort || en_off || sleep_abort || done_ev) begin
        state <= adc_seq_pkg::ST_IDLE;
      end else if (half_tick) begin
        case (state)
          adc_seq_pkg::ST_SAMPLE: begin
            half_cnt <= half_cnt + 5'd1;
            if (half_cnt == `SAMPLE_HALVES - 5'd1) begin
              state   <= adc_seq_pkg::ST_CONVERT;
              code    <= 10'h200;
              bit_idx <= `MSB_IDX;
              sub     <= 1'b0;
            end
          end
          adc_seq_pkg::ST_CONVERT: begin
            half_cnt <= half_cnt + 5'd1;
            sub      <= !sub;
            if (sub) begin
              code[bit_idx] <= cmp_in;
              if (bit_idx != 4'd0) begin
                code[bit_idx - 4'd1] <= 1'b1;
                bit_idx              <= bit_idx - 4'd1;
              end
            end
          end
          default: state <= adc_seq_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // converter held off during sleep while the enable bit still reads one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      sleep_off <= 1'b0;
    else if (ce) begin
      if (!sleep)
        sleep_off <= 1'b0;
      else if (sleep_abort || (done_ev && !conv_irq_enable))
        sleep_off <= 1'b1;
    end
  end

  // analog core controls
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      core_ctrl <= '0;
    else if (ce) begin
      core_ctrl.power     <= conv_enable && !sleep_off;
      core_ctrl.sample    <= (state == adc_seq_pkg::ST_SAMPLE);
      core_ctrl.trial     <= code;
      core_ctrl.ext_en    <= (channel_select <= `CH_EXT_MAX);
      core_ctrl.ext_chan  <= channel_select[3:0];
      core_ctrl.temp_en   <= (channel_select == `CH_TEMP);
      core_ctrl.dac_en    <= (channel_select == `CH_DAC);
      core_ctrl.fixed_en  <= (channel_select == `CH_FIXED);
      core_ctrl.ref_src   <= adc_seq_pkg::ref_sel_e'(pos_ref_select);
      core_ctrl.ref_valid <= (pos_ref_select != adc_seq_pkg::REF_RESERVED);
    end
  end

  // interrupt request and wake
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq  <= 1'b0;
      wake <= 1'b0;
    end else if (ce) begin
      irq  <= conv_done_flag && conv_irq_enable;
      wake <= sleep && conv_done_flag && conv_irq_enable;
    end
  end

  // read data mux
  logic [7:0] rd_byte;
  logic       rd_hit;
  always_comb begin
    rd_hit  = 1'b1;
    rd_byte = 8'h00;
    case (paddr)
      `OFF_CTRL0:    rd_byte = {1'b0, channel_select, busy, conv_enable};
      `OFF_CTRL1:    rd_byte = {result_format_sel, conv_clock_select, 2'b00, pos_ref_select};
      `OFF_CTRL2:    rd_byte = {trigger_select, 3'b000};
      `OFF_RES_HIGH: rd_byte = result_high;
      `OFF_RES_LOW:  rd_byte = result_low;
      `OFF_IRQ:      rd_byte = {6'h00, conv_irq_enable, conv_done_flag};
      default:       rd_hit  = 1'b0;
    endcase
  end

  // one access cycle, no extra wait states
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (ce) begin
      pready <= psel && !penable && !pready;
      if (psel && !penable) begin
        prdata  <= {24'h000000, rd_byte};
        pslverr <= !rd_hit;
      end
    end
  end

  // checks
  localparam int CONV_LAST = 22;
  logic [5:0] busy_cycles;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      busy_cycles <= 6'd0;
    else if (ce) begin
      if (start)
        busy_cycles <= 6'd0;
      else if (busy)
        busy_cycles <= busy_cycles + 6'd1;
    end
  end

  property p_flag_on_done;
    @(posedge clk) disable iff (!rst_n) done_ev |=> conv_done_flag;
  endproperty
  a_flag_on_done: assert property (p_flag_on_done) else $error("done flag not set");

  property p_flag_held;
    @(posedge clk) disable iff (!rst_n)
      conv_done_flag && !(wr_irq && !pwdata[`IRQ_FLAG]) |=> conv_done_flag;
  endproperty
  a_flag_held: assert property (p_flag_held) else $error("done flag dropped by hardware");

  property p_irq_cause;
    @(posedge clk) disable iff (!rst_n) ce && irq |-> $past(conv_done_flag) && $past(conv_irq_enable);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without enabled flag");

  property p_wake;
    @(posedge clk) disable iff (!rst_n) ce && sleep && conv_done_flag && conv_irq_enable |=> wake;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake from sleep");

  property p_right_just;
    @(posedge clk) disable iff (!rst_n)
      done_ev && result_format_sel |=> result_high[7:2] == 6'h00 && result_low == $past(final_code[7:0]);
  endproperty
  a_right_just: assert property (p_right_just) else $error("right justified result wrong");

  property p_power_off;
    @(posedge clk) disable iff (!rst_n) ce && !conv_enable |=> !core_ctrl.power;
  endproperty
  a_power_off: assert property (p_power_off) else $error("converter powered while disabled");

  property p_go_start;
    @(posedge clk) disable iff (!rst_n) sw_start && !sleep_off && !sleep |=> busy;
  endproperty
  a_go_start: assert property (p_go_start) else $error("go write did not start");

  property p_go_clears;
    @(posedge clk) disable iff (!rst_n) done_ev |=> !busy;
  endproperty
  a_go_clears: assert property (p_go_clears) else $error("go not cleared at done");

  property p_length;
    @(posedge clk) disable iff (!rst_n)
      done_ev && conv_clock_select == 3'b000 |-> busy_cycles == CONV_LAST;
  endproperty
  a_length: assert property (p_length) else $error("conversion length wrong");

  property p_sleep_abort;
    @(posedge clk) disable iff (!rst_n) sleep_abort |=> !busy && sleep_off && conv_enable;
  endproperty
  a_sleep_abort: assert property (p_sleep_abort) else $error("sleep did not abort");

  property p_no_trig;
    @(posedge clk) disable iff (!rst_n) trigger_select == `TRIG_NONE |-> !hw_start;
  endproperty
  a_no_trig: assert property (p_no_trig) else $error("trigger while disabled");

  property p_trig_ignored;
    @(posedge clk) disable iff (!rst_n)
      ce && busy && trig_src[trigger_select] && !trig_prev |-> !start;
  endproperty
  a_trig_ignored: assert property (p_trig_ignored) else $error("trigger restarted conversion");

  c_done:  cover property (@(posedge clk) disable iff (!rst_n) done_ev);
  c_abort: cover property (@(posedge clk) disable iff (!rst_n) sw_abort && state == adc_seq_pkg::ST_CONVERT);
  c_trig:  cover property (@(posedge clk) disable iff (!rst_n) hw_start);
  c_wake:  cover property (@(posedge clk) disable iff (!rst_n) wake);

endmodule : adc_conversion_sequencer

// ### core_model.sv
`timescale 1ns/1ps

module core_model (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  // from the sequencer, and the analog level to convert
  input  wire adc_seq_pkg::core_ctrl_s    core_ctrl,
  input  wire logic [9:0]                 level,
  // to the sequencer
  output logic                            cmp_in,
  output logic                            rc_tick
);
  logic [1:0] rc_cnt;
  logic       junk;

  // rc oscillator runs free, one half period every third clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rc_cnt <= 2'h0;
    end else begin
      rc_cnt <= (rc_cnt == 2'h2) ? 2'h0 : rc_cnt + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      junk <= 1'b0;
    end else begin
      junk <= ~junk;
    end
  end

  assign rc_tick = (rc_cnt == 2'h2);
  // unpowered comparator gives garbage, never a held answer
  assign cmp_in  = core_ctrl.power ? (core_ctrl.trial <= level) : junk;
endmodule : core_model

// ### testbench.sv
`timescale 1ns/1ps
`include "adc_seq_consts.svh"

module testbench;
  logic                    clk, rst_n, psel, penable, pwrite, sleep;
  logic                    pready, pslverr, cmp_in, rc_tick, wake, irq;
  logic [11:0]             paddr;
  logic [31:0]             pwdata, prdata, trig_src;
  logic [9:0]              level;
  adc_seq_pkg::core_ctrl_s core_ctrl;
  int                      mismatches, samples_checked;

  adc_conversion_sequencer #(.NUM_TRIG(32)) i_adc_conversion_sequencer (
    .clk(clk), .rst_n(rst_n), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmp_in(cmp_in), .rc_tick(rc_tick),
    .core_ctrl(core_ctrl), .trig_src(trig_src), .sleep(sleep), .wake(wake), .irq(irq));

  core_model i_core_model (.clk(clk), .rst_n(rst_n), .core_ctrl(core_ctrl),
    .level(level), .cmp_in(cmp_in), .rc_tick(rc_tick));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    r = prdata;
    e = pslverr;
    if (n >= 64) mismatches++;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task rdc(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
  endtask : rdc

  task wait_idle;
    logic [31:0] r;
    logic        e;
    int          n;
    n = 0;
    do begin
      apb(1'b0, `OFF_CTRL0, 32'h0, r, e);
      n++;
    end while (r[1] !== 1'b0 && n < 200);
    if (n >= 200) mismatches++;
  endtask : wait_idle

  task t_regs;
    logic [31:0] r;
    logic        e;
    wr(`OFF_CTRL0, 32'h3);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    chk(core_ctrl.power, 0);
    for (int a = 0; a < 24; a += 4) rdc(a[11:0], 32'h0);
    apb(1'b0, 12'h018, 32'h0, r, e);
    chk({31'h0, e}, 1);
    wr(`OFF_CTRL0, 32'hff);
    rdc(`OFF_CTRL0, 32'h7d);
    wr(`OFF_CTRL1, 32'hff);
    rdc(`OFF_CTRL1, 32'hf3);
    wr(`OFF_CTRL2, 32'hff);
    rdc(`OFF_CTRL2, 32'hf8);
    wr(`OFF_CTRL2, 32'h0);
    $display("test regs done");
  endtask : t_regs

  task t_decode;
    logic [4:0] codes [6];
    logic [4:0] c;
    codes = '{5'h00, 5'h0b, 5'h0c, 5'h1d, 5'h1e, 5'h1f};
    foreach (codes[i]) begin
      c = codes[i];
      wr(`OFF_CTRL0, {25'h0, c, 2'b01});
      repeat (2) @(posedge clk);
      chk({core_ctrl.ext_en, core_ctrl.temp_en, core_ctrl.dac_en, core_ctrl.fixed_en},
          {c <= 5'h0b, c == 5'h1d, c == 5'h1e, c == 5'h1f});
      if (c <= 5'h0b) chk(core_ctrl.ext_chan, c[3:0]);
    end
    for (int r = 0; r < 4; r++) begin
      wr(`OFF_CTRL1, r);
      repeat (2) @(posedge clk);
      chk({core_ctrl.ref_src, core_ctrl.ref_valid}, {r[1:0], r != 1});
    end
    chk(core_ctrl.power, 1);
    wr(`OFF_CTRL0, 32'h0);
    repeat (2) @(posedge clk);
    chk(core_ctrl.power, 0);
    $display("test decode done");
  endtask : t_decode

  task t_conv(input logic [2:0] cs, input logic fmt, input int m);
    int n;
    wr(`OFF_CTRL1, {24'h0, fmt, cs, 4'h0});
    wr(`OFF_IRQ, 32'h2);
    wr(`OFF_CTRL0, 32'h1);
    wr(`OFF_CTRL0, 32'h3);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (irq !== 1'b1 && n < 2000);
    chk(n, 23 * m + 2);
    rdc(`OFF_CTRL0, 32'h1);
    rdc(`OFF_IRQ, 32'h3);
    rdc(`OFF_RES_HIGH, fmt ? {30'h0, level[9:8]} : {24'h0, level[9:2]});
    rdc(`OFF_RES_LOW, fmt ? {24'h0, level[7:0]} : {24'h0, level[1:0], 6'h0});
    wr(`OFF_IRQ, 32'h2);
    repeat (2) @(posedge clk);
    chk(irq, 0);
    $display("test conv done");
  endtask : t_conv

  task t_abort;
    level = 10'h3c0;
    wr(`OFF_CTRL1, 32'h80);
    wr(`OFF_CTRL0, 32'h1);
    wr(`OFF_CTRL0, 32'h3);
    rdc(`OFF_CTRL0, 32'h3);
    repeat (3) @(posedge clk);
    wr(`OFF_CTRL0, 32'h1);
    rdc(`OFF_RES_HIGH, 32'h3);
    rdc(`OFF_RES_LOW, 32'hff);
    $display("test abort done");
  endtask : t_abort

  task t_trig;
    wr(`OFF_IRQ, 32'h0);
    wr(`OFF_CTRL1, 32'h0);
    wr(`OFF_CTRL2, 32'h28);
    trig_src <= 32'h20;
    repeat (3) @(posedge clk);
    rdc(`OFF_CTRL0, 32'h3);
    trig_src <= 32'h0;
    @(posedge clk);
    trig_src <= 32'h20;
    // a restart on this edge would still read busy here
    repeat (18) @(posedge clk);
    rdc(`OFF_CTRL0, 32'h1);
    rdc(`OFF_IRQ, 32'h1);
    wr(`OFF_CTRL2, 32'h0);
    trig_src <= 32'h0;
    repeat (2) @(posedge clk);
    trig_src <= 32'hffffffff;
    repeat (4) @(posedge clk);
    rdc(`OFF_CTRL0, 32'h1);
    trig_src <= 32'h0;
    $display("test trig done");
  endtask : t_trig

  task t_sleep;
    int n;
    level = 10'h155;
    wr(`OFF_CTRL1, 32'h60);
    wr(`OFF_CTRL0, 32'h3);
    sleep <= 1'b1;
    repeat (3) @(posedge clk);
    chk(core_ctrl.power, 0);
    rdc(`OFF_CTRL0, 32'h1);
    sleep <= 1'b0;
    wr(`OFF_CTRL1, 32'h30);
    wr(`OFF_IRQ, 32'h2);
    wr(`OFF_CTRL0, 32'h3);
    sleep <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wake !== 1'b1 && n < 1000);
    chk(wake, 1);
    rdc(`OFF_RES_HIGH, 32'h55);
    sleep <= 1'b0;
    wr(`OFF_IRQ, 32'h0);
    wr(`OFF_CTRL0, 32'h3);
    sleep <= 1'b1;
    wait_idle();
    chk(core_ctrl.power, 0);
    rdc(`OFF_CTRL0, 32'h1);
    sleep <= 1'b0;
    $display("test sleep done");
  endtask : t_sleep

  task wrap_up;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  initial begin
    rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; sleep = 1'b0;
    paddr = 12'h0; pwdata = 32'h0; trig_src = 32'h0; level = 10'h2d7;
    mismatches = 0; samples_checked = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_decode();
    t_conv(3'b000, 1'b1, 1);
    t_conv(3'b100, 1'b0, 2);
    t_abort();
    t_trig();
    t_sleep();
    wrap_up();
  end

  // whole run needs well under ten thousand cycles
  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    wrap_up();
  end
endmodule : testbench
